// ### design/acss_map.vh
`ifndef ACSS_MAP_VH
`define ACSS_MAP_VH
// configuration word fields
`define ACSS_CFG_CH_HI 14
`define ACSS_CFG_CH_LO 12
`define ACSS_CFG_COM_BIT 11
`define ACSS_CFG_GAIN_HI 9
`define ACSS_CFG_GAIN_LO 7
`define ACSS_CFG_AUXEX_BIT 6
`define ACSS_CFG_SEQ_HI 5
`define ACSS_CFG_SEQ_LO 4
`define ACSS_CFG_TOFF_BIT 3
`define ACSS_CFG_CMS_BIT 1
`define ACSS_CFG_UPD_BIT 15
// gain list words
`define ACSS_GL_WREN_BIT 15
// sequencer modes
`define ACSS_SEQ_OFF 2'h0
`define ACSS_SEQ_UPD 2'h1
`define ACSS_SEQ_ADV 2'h2
`define ACSS_SEQ_BASIC 2'h3
// reset values
`define ACSS_CFG_RESET 16'h3C49
`define ACSS_WORD_BITS 16
// mux select codes: 0..7 inputs, 8 temperature, 9 aux
`define ACSS_SEL_TEMP 4'h8
`define ACSS_SEL_AUX 4'h9
// temperature spacing: 5 us
`define ACSS_TEMP_GAP_NS 5000
`define ACSS_CLK_NS 50
`endif

// ### design/acss_sdi_rx.v
`include "acss_map.vh"
// serial word receiver, link sampled by the system clock
module acss_sdi_rx
(
  // clock
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  // link pins
  input wire sck_in,
  input wire cs_n_in,
  input wire sdi_in,
  // word out
  output reg [15:0] word_out,
  output reg word_valid_out,
  output reg first_bit_out
);
reg [2:0] sck_s;
reg [2:0] cs_s;
reg [2:0] sdi_s;
reg [4:0] cnt;
reg [15:0] shreg;
reg sck_f;
reg cs_f;
reg sdi_f;
always @(posedge sys_clk_in)
begin
  if (!rst_n_in)
  begin
    sck_s <= 3'h0;
    cs_s <= 3'h7;
    sdi_s <= 3'h0;
    sck_f <= 1'b0;
    cs_f <= 1'b1;
    sdi_f <= 1'b0;
    cnt <= 5'h00;
    shreg <= 16'h0000;
    word_out <= 16'h0000;
    word_valid_out <= 1'b0;
    first_bit_out <= 1'b0;
  end
  else if (clk_en_in)
  begin
    sck_s <= {sck_s[1:0], sck_in};
    cs_s <= {cs_s[1:0], cs_n_in};
    sdi_s <= {sdi_s[1:0], sdi_in};
    // change accepted once stages two and three agree
    if (sck_s[1] == sck_s[2])
      sck_f <= sck_s[2];
    if (cs_s[1] == cs_s[2])
      cs_f <= cs_s[2];
    if (sdi_s[1] == sdi_s[2])
      sdi_f <= sdi_s[2];
    word_valid_out <= 1'b0;
    if (cs_f)
      cnt <= 5'h00;
    else if (sck_s[1] == sck_s[2] && sck_s[2] && !sck_f)
    begin
      // bits past the sixteenth are ignored
      if (cnt < `ACSS_WORD_BITS)
      begin
        shreg <= {shreg[14:0], sdi_f};
        cnt <= cnt + 5'h01;
        if (cnt == 5'h00)
          first_bit_out <= sdi_f;
        if (cnt == 5'h0F)
        begin
          word_out <= {shreg[14:0], sdi_f};
          word_valid_out <= 1'b1;
        end
      end
    end
  end
end
endmodule // acss_sdi_rx

// ### design/acss_seq.v
`include "acss_map.vh"
// What this block does
// - after last measurement, wrap to channel or pair zero; repeat until disabled or down
// - sequencing pairs always take even input positive, odd negative
// - sequencer off, channel field sets pair polarity
// - aux excluded and temperature off: inputs only, up to last channel
// - pairs formed from last channel; 110 or 111 scans all four pairs
// - aux exclude zero appends one aux pair conversion per loop
// - temperature off low appends a temperature conversion
// - with both appended: inputs, then temperature, then aux
// - temperature results are straight binary
// - last conversion on leaving the sequencer by a mode 00 write is flagged invalid; power down leaves unflagged
// - mode 11 basic, 01 update during sequence, 10 advanced gains
// - configuration updates take effect through a two-deep delay
// - basic scan begins on second conversion after the enabling latch
// - update mode applies at n+2; last channel or common change restarts
// - advanced mode expects gain list words, each at its own conversion
// - only the first 16 bits of a transfer are latched
// - channel zero gain from configuration word; pairs need only first list
// - first list bit15 loads or returns; gains at 10:8, 6:4, 2:0
// - second list bit15 loads or returns; gains at 14:12 .. 2:0
module acss_seq
(
  // clock and control
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire power_down_input_in,
  // serial link
  input wire sck_in,
  input wire cs_n_in,
  input wire sdi_in,
  // end of conversion from the converter core
  input wire eoc_in,
  // mux and front end
  output reg [3:0] sel_out,
  output reg [2:0] pos_ch_out,
  output reg [2:0] neg_ch_out,
  output reg to_com_out,
  output reg [2:0] gain_range_setting_out,
  output reg conversion_mode_select_out,
  output reg straight_binary_out,
  output reg result_invalid_out,
  output reg seq_active_out
);
localparam ST_IDLE = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_GL0 = 2'h2;
localparam ST_GL1 = 2'h3;

wire [15:0] rx_word;
wire rx_valid;
wire rx_first;
reg [15:0] pend;
reg pend_v;
reg [15:0] stage;
reg stage_v;
reg [15:0] cfg;
reg [15:0] gain_list_first;
reg [15:0] gain_list_second;
reg [1:0] state;
reg [3:0] pos;
reg [1:0] start_dly;

acss_sdi_rx u_rx
(
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in),
  .sck_in(sck_in),
  .cs_n_in(cs_n_in),
  .sdi_in(sdi_in),
  .word_out(rx_word),
  .word_valid_out(rx_valid),
  .first_bit_out(rx_first)
);

////////////////////////////////////////////////////////////////////////////////
// decoders

function [3:0] fn_last_pos;
  input [15:0] w;
  begin
    if (w[`ACSS_CFG_COM_BIT])
      fn_last_pos = {1'b0, w[`ACSS_CFG_CH_HI:`ACSS_CFG_CH_LO]};
    else
      fn_last_pos = {2'b00, w[`ACSS_CFG_CH_HI:`ACSS_CFG_CH_LO+1]};
  end
endfunction

function [3:0] fn_next;
  input [15:0] w;
  input [3:0] p;
  reg [3:0] lp;
  begin
    lp = fn_last_pos(w);
    if (p < 4'h8 && p < lp)
      fn_next = p + 4'h1;
    else if (p < 4'h8 && !w[`ACSS_CFG_TOFF_BIT])
      fn_next = `ACSS_SEL_TEMP;
    else if (p < 4'h9 && !w[`ACSS_CFG_AUXEX_BIT])
      fn_next = `ACSS_SEL_AUX;
    else
      fn_next = 4'h0;
  end
endfunction

function [2:0] fn_gain;
  input [15:0] w;
  input [15:0] g0;
  input [15:0] g1;
  input [3:0] p;
  input adv;
  begin
    fn_gain = w[`ACSS_CFG_GAIN_HI:`ACSS_CFG_GAIN_LO];
    if (adv && p != 4'h0 && p < 4'h8)
    begin
      case (p)
        4'h1: fn_gain = g0[10:8];
        4'h2: fn_gain = g0[6:4];
        4'h3: fn_gain = g0[2:0];
        4'h4: fn_gain = g1[14:12];
        4'h5: fn_gain = g1[10:8];
        4'h6: fn_gain = g1[6:4];
        default: fn_gain = g1[2:0];
      endcase
    end
  end
endfunction

wire [1:0] mode = cfg[`ACSS_CFG_SEQ_HI:`ACSS_CFG_SEQ_LO];
wire [1:0] new_mode = stage[`ACSS_CFG_SEQ_HI:`ACSS_CFG_SEQ_LO];
wire restart_chg = (stage[`ACSS_CFG_CH_HI:`ACSS_CFG_CH_LO] !=
  cfg[`ACSS_CFG_CH_HI:`ACSS_CFG_CH_LO]) ||
  (stage[`ACSS_CFG_COM_BIT] != cfg[`ACSS_CFG_COM_BIT]);
wire gl_needed1 = cfg[`ACSS_CFG_COM_BIT] && (fn_last_pos(cfg) > 4'h3);

////////////////////////////////////////////////////////////////////////////////
// word pipeline and sequencer

always @(posedge sys_clk_in)
begin
  if (!rst_n_in)
  begin
    pend <= 16'h0000;
    pend_v <= 1'b0;
    stage <= `ACSS_CFG_RESET;
    stage_v <= 1'b0;
    cfg <= `ACSS_CFG_RESET;
    gain_list_first <= 16'h0000;
    gain_list_second <= 16'h0000;
    state <= ST_IDLE;
    pos <= 4'h0;
    start_dly <= 2'h0;
    result_invalid_out <= 1'b0;
  end
  else if (clk_en_in)
  begin
    if (rx_valid)
    begin
      // while running, a low first bit means readback only
      if (state == ST_IDLE || rx_first || state == ST_GL0 || state == ST_GL1)
      begin
        pend <= rx_word;
        pend_v <= 1'b1;
      end
    end
    if (power_down_input_in)
    begin
      state <= ST_IDLE;
      pos <= 4'h0;
      start_dly <= 2'h0;
      stage_v <= 1'b0;
      pend_v <= 1'b0;
      cfg[`ACSS_CFG_SEQ_HI:`ACSS_CFG_SEQ_LO] <= `ACSS_SEQ_OFF;
    end
    else if (eoc_in)
    begin
      // two-deep: word caught at one eoc, applied at the next
      stage <= pend;
      stage_v <= pend_v;
      pend_v <= 1'b0;
      result_invalid_out <= 1'b0;
      if (start_dly != 2'h0)
        start_dly <= start_dly - 2'h1;
      else if (state == ST_RUN)
        pos <= fn_next(cfg, pos);
      if (stage_v)
      begin
        case (state)
          ST_GL0:
          begin
            if (stage[`ACSS_GL_WREN_BIT])
              state <= ST_IDLE;
            else
            begin
              gain_list_first <= stage;
              state <= gl_needed1 ? ST_GL1 : ST_RUN;
              pos <= 4'h0;
            end
          end
          ST_GL1:
          begin
            if (stage[`ACSS_GL_WREN_BIT])
              state <= ST_IDLE;
            else
            begin
              gain_list_second <= stage;
              state <= ST_RUN;
              pos <= 4'h0;
            end
          end
          default:
          begin
            if (state == ST_RUN && new_mode == `ACSS_SEQ_UPD && mode != `ACSS_SEQ_OFF)
            begin
              cfg <= {stage[15:6], mode, stage[3:0]};
              if (restart_chg)
                pos <= 4'h0;
            end
            else
            begin
              cfg <= stage;
              pos <= 4'h0;
              case (new_mode)
                `ACSS_SEQ_BASIC:
                begin
                  state <= ST_RUN;
                  start_dly <= 2'h1;
                end
                `ACSS_SEQ_ADV: state <= ST_GL0;
                `ACSS_SEQ_UPD: state <= ST_RUN;
                default:
                begin
                  if (state == ST_RUN)
                    result_invalid_out <= 1'b1;
                  state <= ST_IDLE;
                end
              endcase
            end
          end
        endcase
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// mux outputs

wire running = (state == ST_RUN) && (start_dly == 2'h0);
wire adv_mode = (mode == `ACSS_SEQ_ADV);
wire [2:0] ch = cfg[`ACSS_CFG_CH_HI:`ACSS_CFG_CH_LO];
always @(posedge sys_clk_in)
begin
  if (!rst_n_in)
  begin
    sel_out <= 4'h0;
    pos_ch_out <= 3'h0;
    neg_ch_out <= 3'h1;
    to_com_out <= 1'b0;
    gain_range_setting_out <= 3'h0;
    conversion_mode_select_out <= 1'b1;
    straight_binary_out <= 1'b0;
    seq_active_out <= 1'b0;
  end
  else if (clk_en_in)
  begin
    seq_active_out <= running;
    conversion_mode_select_out <= cfg[`ACSS_CFG_CMS_BIT];
    to_com_out <= cfg[`ACSS_CFG_COM_BIT];
    if (running)
    begin
      sel_out <= pos;
      straight_binary_out <= (pos == `ACSS_SEL_TEMP);
      gain_range_setting_out <= fn_gain(cfg, gain_list_first, gain_list_second,
        pos, adv_mode);
      if (cfg[`ACSS_CFG_COM_BIT])
      begin
        pos_ch_out <= pos[2:0];
        neg_ch_out <= pos[2:0];
      end
      else
      begin
        pos_ch_out <= {pos[1:0], 1'b0};
        neg_ch_out <= {pos[1:0], 1'b1};
      end
    end
    else
    begin
      sel_out <= {1'b0, ch};
      straight_binary_out <= 1'b0;
      gain_range_setting_out <= cfg[`ACSS_CFG_GAIN_HI:`ACSS_CFG_GAIN_LO];
      pos_ch_out <= ch;
      if (cfg[`ACSS_CFG_COM_BIT])
        neg_ch_out <= ch;
      else
        neg_ch_out <= {ch[2:1], ~ch[0]};
    end
  end
end
endmodule // acss_seq

// ### verif/acss_checker.sv
`include "acss_map.vh"
module acss_checker
(
  // clock and control
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic power_down_input_in,
  input wire logic eoc_in,
  // mux and front end
  input wire logic [3:0] sel_out,
  input wire logic [2:0] pos_ch_out,
  input wire logic [2:0] neg_ch_out,
  input wire logic to_com_out,
  input wire logic [2:0] gain_range_setting_out,
  input wire logic straight_binary_out,
  input wire logic result_invalid_out,
  input wire logic seq_active_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////
  a_temp_binary: assert property (straight_binary_out == (sel_out == `ACSS_SEL_TEMP))
    else $error("coding flag wrong");
  a_pair_even: assert property (seq_active_out && !to_com_out && sel_out < 4'h8
    |-> !pos_ch_out[0] && neg_ch_out == (pos_ch_out | 3'h1)) else $error("pair terminals");
  a_off_polarity: assert property (!seq_active_out && !to_com_out && sel_out < 4'h8
    |-> neg_ch_out == (pos_ch_out ^ 3'h1)) else $error("off terminals");
  a_com_equal: assert property (to_com_out && sel_out < 4'h8
    |-> pos_ch_out == neg_ch_out) else $error("common terminals");
  a_aux_last: assert property (seq_active_out && $past(seq_active_out) &&
    $past(sel_out) == `ACSS_SEL_AUX && sel_out != `ACSS_SEL_AUX |-> sel_out == 4'h0)
    else $error("aux not last");
  a_temp_then_aux: assert property (seq_active_out && $past(seq_active_out) &&
    $past(sel_out) == `ACSS_SEL_TEMP && sel_out != `ACSS_SEL_TEMP
    |-> sel_out == `ACSS_SEL_AUX || sel_out == 4'h0) else $error("temp order");
  a_scan_step: assert property (seq_active_out && $past(seq_active_out) &&
    $past(sel_out) < 4'h8 && sel_out != $past(sel_out) |-> sel_out == 4'h0 ||
    sel_out >= 4'h8 || sel_out == $past(sel_out) + 4'h1 || sel_out == $past(sel_out) + 4'h2)
    else $error("scan step");
  a_invalid_exit: assert property ($fell(seq_active_out) && !power_down_input_in
    |-> ##[0:3] result_invalid_out) else $error("exit not flagged");
  a_invalid_cause: assert property ($rose(result_invalid_out)
    |-> $past(eoc_in) || $past(eoc_in, 2) || $past(eoc_in, 3)) else $error("flag without eoc");
  a_pd_stops: assert property (power_down_input_in [*3] |-> !seq_active_out)
    else $error("scan under power down");
  a_gain_hold: assert property ($past(rst_n_in) && $past(rst_n_in, 2) && !$past(eoc_in) &&
    !$past(eoc_in, 2) && !$past(eoc_in, 3) && !$past(power_down_input_in) &&
    !$past(power_down_input_in, 2) |-> $stable(gain_range_setting_out))
    else $error("gain moved between eocs");
endmodule // acss_checker

// ### verif/acss_host.sv
module acss_host
(
  // link pins
  output logic sck_out,
  output logic cs_n_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // link clock only runs inside a frame
  task automatic send(input logic [15:0] w);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_out = w[i];
      #200 sck_out = 1'b1;
      #200 sck_out = 1'b0;
    end
    #200 cs_n_out = 1'b1;
    // released line must not keep its last level
    sdi_out = ~sdi_out;
  endtask
endmodule // acss_host

// ### verif/tb_adc_channel_scan_sequencer.sv
module tb_adc_channel_scan_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic pd = 1'b0;
  logic eoc = 1'b0;
  wire sck, cs_n, sdi, com, conversion_mode_select, sbin, inv, act;
  wire [3:0] sel;
  wire [2:0] pos, neg, gain;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] lfsr = 32'h000111D2;
  logic [5:0] corner [7] = '{6'h1F, 6'h3F, 6'h33, 6'h3E, 6'h3D, 6'h3C, 6'h0B};
  always #25 sys_clk_in = ~sys_clk_in;
  acss_host i_host (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi));
  acss_seq i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .power_down_input_in(pd), .sck_in(sck), .cs_n_in(cs_n), .sdi_in(sdi), .eoc_in(eoc),
    .sel_out(sel), .pos_ch_out(pos), .neg_ch_out(neg), .to_com_out(com),
    .gain_range_setting_out(gain), .conversion_mode_select_out(conversion_mode_select),
    .straight_binary_out(sbin), .result_invalid_out(inv), .seq_active_out(act));
  //////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return lfsr;
  endfunction
  function automatic logic [15:0] cfg(input logic [2:0] n, input logic c, ax, tf,
    input logic [1:0] sq, input logic [2:0] g);
    return {1'b1, n, c, 1'b0, g, ax, sq, tf, 3'h2};
  endfunction
  function automatic int expc(input int n, c, ax, tf, i);
    int m;
    m = c ? n + 1 : n / 2 + 1;
    if (i < m)
      return c ? i : 2 * i;
    return (i == m && !tf) ? 8 : 9;
  endfunction
  function automatic logic [2:0] gexp(input int p, input logic [2:0] g, input logic [15:0] a, b);
    if (p == 0)
      return g;
    return 3'(p < 4 ? a >> (4 * (3 - p)) : b >> (4 * (7 - p)));
  endfunction
  function automatic logic [15:0] code();
    return (sel >= 4'h8) ? {12'h000, sel} : {13'h0000, pos};
  endfunction
  //////////////////////////////
  task automatic compare(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
  endtask
  task automatic conv();
    @(negedge sys_clk_in) eoc = 1'b1;
    @(negedge sys_clk_in) eoc = 1'b0;
    repeat (102) @(negedge sys_clk_in);
  endtask
  task automatic xfer(input logic [15:0] w);
    i_host.send(w);
    conv();
  endtask
  task automatic scan_case(input logic [2:0] n, input logic c, ax, tf, input logic [2:0] g);
    int len;
    len = (c ? int'(n) + 1 : int'(n) / 2 + 1) + int'(!tf) + int'(!ax);
    do_reset();
    xfer(cfg(n, c, ax, tf, 2'h3, g));
    conv();
    conv();
    compare({15'h0000, act}, 16'h0001, "active");
    // a frozen clock must swallow this eoc
    clk_en_in = 1'b0;
    conv();
    clk_en_in = 1'b1;
    for (int k = 0; k <= 2 * len; k++)
    begin
      if (k > 0)
        conv();
      compare(code(), 16'(expc(n, c, ax, tf, k % len)), "scan");
      compare({13'h0000, gain}, {13'h0000, g}, "gain");
      compare({15'h0000, sbin}, {15'h0000, (expc(n, c, ax, tf, k % len) == 8)}, "coding");
    end
    xfer({1'b0, 15'(rnd())});
    compare(code(), 16'(expc(n, c, ax, tf, (2 * len + 1) % len)), "readback");
    xfer(cfg(n, c, ax, tf, 2'h1, ~g) ^ 16'h0002);
    conv();
    compare({12'h000, conversion_mode_select, gain}, {12'h000, 1'b0, ~g}, "update");
    xfer(cfg(n, c, ax, tf, 2'h0, g));
    conv();
    compare({11'h000, inv, act, pos}, {11'h000, 1'b1, 1'b0, n}, "exit");
  endtask
  //////////////////////////////
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic [15:0] w0, w1;
    logic [2:0] g;
    for (int j = 0; j < 7; j++)
      scan_case(corner[j][5:3], corner[j][2], corner[j][1], corner[j][0], 3'(rnd()));
    repeat (4)
    begin
      r = rnd();
      scan_case(r[2:0], r[3], r[4], r[5], r[8:6]);
    end
    do_reset();
    g = 3'(rnd());
    w0 = 16'(rnd()) & 16'h0777;
    w1 = 16'(rnd()) & 16'h7777;
    xfer(cfg(3'h7, 1'b1, 1'b1, 1'b1, 2'h2, g));
    xfer(w0);
    xfer(w1);
    repeat (4) conv();
    for (int i = 0; i < 16; i++)
    begin
      conv();
      compare({13'h0000, pos}, 16'((4 + i) % 8), "advanced order");
      compare({13'h0000, gain}, {13'h0000, gexp(int'(pos), g, w0, w1)}, "advanced");
    end
    xfer(cfg(3'h3, 1'b1, 1'b1, 1'b1, 2'h0, g));
    conv();
    compare({14'h0000, inv, act}, 16'h0002, "abort");
    xfer(cfg(3'h7, 1'b1, 1'b1, 1'b1, 2'h3, g));
    repeat (3) conv();
    pd = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    compare({15'h0000, act}, 16'h0000, "power down");
    pd = 1'b0;
    xfer(cfg(3'h3, 1'b1, 1'b1, 1'b1, 2'h2, g));
    xfer(16'h8000 | w0);
    conv();
    compare({15'h0000, act}, 16'h0000, "list return");
    conclude();
  end
endmodule // tb_adc_channel_scan_sequencer

bind acss_seq acss_checker i_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .power_down_input_in(power_down_input_in), .eoc_in(eoc_in), .sel_out(sel_out),
  .pos_ch_out(pos_ch_out), .neg_ch_out(neg_ch_out), .to_com_out(to_com_out),
  .gain_range_setting_out(gain_range_setting_out), .straight_binary_out(straight_binary_out),
  .result_invalid_out(result_invalid_out), .seq_active_out(seq_active_out));
